/* File: page_select_pkg.sv */
// constants and types shared by the serial page-selection logic
package page_select_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int SLOTS = 3;
   localparam int SLOT_IDX_W = 2;

   // selector location and layout
   localparam logic [ADDR_W-1:0] SEL_ADDR = 10'h3FF;
   localparam int COMMON_BIT = 8;
   localparam int PICK_LSB = 0;
   localparam logic [DATA_W-1:0] SEL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] SEL_COMMON_VALUE = 16'h0100;
   localparam logic [DATA_W-1:0] SEL_PICK_MASK = 16'h0007;

   // pick encodings
   localparam logic [SLOTS-1:0] PICK_NONE = 3'h0;
   localparam logic [SLOTS-1:0] PICK_SLOT1 = 3'h1;
   localparam logic [SLOTS-1:0] PICK_SLOT2 = 3'h2;
   localparam logic [SLOTS-1:0] PICK_SLOT3 = 3'h4;
   localparam logic [SLOT_IDX_W-1:0] IDX_SLOT1 = 2'h0;
   localparam logic [SLOT_IDX_W-1:0] IDX_SLOT2 = 2'h1;
   localparam logic [SLOT_IDX_W-1:0] IDX_SLOT3 = 2'h2;

   // code RAM size and the part of it the serial port can reach
   localparam int CRAM_DEPTH = 1024;
   localparam int CRAM_USABLE = CRAM_DEPTH - 1;

   localparam logic [DATA_W-1:0] RDATA_NONE = 16'h0000;

   // where a read answer comes from
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_SEL,
      SRC_CRAM,
      SRC_COMMON
   } rd_src_t;

endpackage : page_select_pkg

/* File: code_ram_port.sv */
// strobe generator for one code RAM channel
`timescale 1ns/1ps
module code_ram_port (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic slot_pick_i,
   input wire logic cram_req_i,
   input wire logic write_i,
   input wire logic read_ok_i,
   output logic wr_o,
   output logic rd_o
);

   logic wr_d;
   logic rd_d;

   // a broadcast pick still writes, but a read needs a single pick
   assign wr_d = cram_req_i && write_i && slot_pick_i;
   assign rd_d = cram_req_i && !write_i && slot_pick_i && read_ok_i;

   // strobes registered so they line up with the registered address and data
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_o <= 1'b0;
         rd_o <= 1'b0;
      end else begin
         wr_o <= wr_d;
         rd_o <= rd_d;
      end
   end

endmodule : code_ram_port

/* File: spi_memory_page_select.sv */
// serial address decoder that steers accesses by the memory page selector
`timescale 1ns/1ps
module spi_memory_page_select (
   input wire logic clock_i,
   input wire logic rst_b_i,
   // decoded serial access, one-cycle request from the serial engine
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [page_select_pkg::ADDR_W-1:0] acc_addr_i,
   input wire logic [page_select_pkg::DATA_W-1:0] acc_wdata_i,
   output logic [page_select_pkg::DATA_W-1:0] acc_rdata_o,
   output logic acc_rvalid_o,
   output logic acc_ignored_o,
   output logic acc_refused_o,
   // code RAM side, one strobe pair per channel
   output logic [page_select_pkg::SLOTS-1:0] cram_wr_o,
   output logic [page_select_pkg::SLOTS-1:0] cram_rd_o,
   output logic [page_select_pkg::ADDR_W-1:0] cram_addr_o,
   output logic [page_select_pkg::DATA_W-1:0] cram_wdata_o,
   input wire logic [page_select_pkg::SLOTS-1:0][page_select_pkg::DATA_W-1:0] cram_rdata_i,
   // common page side: data RAMs and configuration registers
   output logic common_wr_o,
   output logic common_rd_o,
   output logic [page_select_pkg::ADDR_W-1:0] common_addr_o,
   output logic [page_select_pkg::DATA_W-1:0] common_wdata_o,
   input wire logic [page_select_pkg::DATA_W-1:0] common_rdata_i,
   // selector state for the rest of the device
   output logic [page_select_pkg::DATA_W-1:0] page_sel_o,
   output logic common_page_o,
   output logic [page_select_pkg::SLOTS-1:0] code_ram_slot_picks_o
);

   // selector register
   logic [page_select_pkg::DATA_W-1:0] sel_q;
   logic [page_select_pkg::DATA_W-1:0] sel_d;

   // first stage: strobes, address and data toward the targets
   logic [page_select_pkg::ADDR_W-1:0] addr_q;
   logic [page_select_pkg::DATA_W-1:0] wdata_q;
   logic common_wr_q;
   logic common_rd_q;
   page_select_pkg::rd_src_t src1_q;
   page_select_pkg::rd_src_t src1_d;
   logic [page_select_pkg::SLOT_IDX_W-1:0] slot1_q;
   logic [page_select_pkg::DATA_W-1:0] selrd1_q;

   // second stage: the targets present read data
   page_select_pkg::rd_src_t src2_q;
   logic [page_select_pkg::SLOT_IDX_W-1:0] slot2_q;
   logic [page_select_pkg::DATA_W-1:0] selrd2_q;
   logic [1:0] ign_pipe_q;
   logic [1:0] ref_pipe_q;

   // third stage: answer to the serial engine
   logic [page_select_pkg::DATA_W-1:0] rdata_q;
   logic [page_select_pkg::DATA_W-1:0] rdata_d;
   logic rvalid_q;
   logic ignored_q;
   logic refused_q;

   // decode of the current selector
   logic common_page;
   logic [page_select_pkg::SLOTS-1:0] code_ram_slot_picks;
   logic code_ram_slot1_pick;
   logic code_ram_slot2_pick;
   logic single_pick;
   logic [page_select_pkg::SLOT_IDX_W-1:0] slot_idx;

   // decode of the incoming access
   logic sel_hit;
   logic sel_write;
   logic mem_req;
   logic common_req;
   logic cram_req;
   logic nothing_req;
   logic refused_req;
   logic is_read;

   assign common_page = sel_q[page_select_pkg::COMMON_BIT];
   assign code_ram_slot_picks = sel_q[page_select_pkg::PICK_LSB +: page_select_pkg::SLOTS];
   assign code_ram_slot1_pick = code_ram_slot_picks[0];
   assign code_ram_slot2_pick = code_ram_slot_picks[1];
   // only a single pick allows reads; broadcast patterns are write-only
   assign single_pick = (code_ram_slot_picks == page_select_pkg::PICK_SLOT1)
                     || (code_ram_slot_picks == page_select_pkg::PICK_SLOT2)
                     || (code_ram_slot_picks == page_select_pkg::PICK_SLOT3);
   assign slot_idx = code_ram_slot1_pick ? page_select_pkg::IDX_SLOT1
                   : code_ram_slot2_pick ? page_select_pkg::IDX_SLOT2
                   : page_select_pkg::IDX_SLOT3;

   // the top address is trapped before any page decode, so it never reaches a RAM
   assign sel_hit = acc_addr_i == page_select_pkg::SEL_ADDR;
   assign sel_write = acc_valid_i && sel_hit && acc_write_i;
   assign is_read = !acc_write_i;
   assign mem_req = acc_valid_i && !sel_hit;
   assign common_req = mem_req && common_page;
   assign cram_req = mem_req && !common_page
                  && (code_ram_slot_picks != page_select_pkg::PICK_NONE);
   assign nothing_req = mem_req && !common_page
                     && (code_ram_slot_picks == page_select_pkg::PICK_NONE);
   assign refused_req = cram_req && is_read && !single_pick;

   // a set common flag wins over the picks; reserved bits never store
   assign sel_d = acc_wdata_i[page_select_pkg::COMMON_BIT]
                ? page_select_pkg::SEL_COMMON_VALUE
                : (acc_wdata_i & page_select_pkg::SEL_PICK_MASK);

   // selector, cleared to nothing selected at reset
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_q <= page_select_pkg::SEL_RESET;
      end else if (sel_write) begin
         sel_q <= sel_d;
      end
   end

   // read source of the access being taken
   always_comb begin
      src1_d = page_select_pkg::SRC_NONE;
      if (acc_valid_i && is_read) begin
         if (sel_hit) begin
            src1_d = page_select_pkg::SRC_SEL;
         end else if (common_req) begin
            src1_d = page_select_pkg::SRC_COMMON;
         end else if (cram_req && single_pick) begin
            src1_d = page_select_pkg::SRC_CRAM;
         end
      end
   end

   // one strobe generator per code RAM channel
   for (genvar g = 0; g < page_select_pkg::SLOTS; g++) begin : g_slot
      code_ram_port u_port (
         .clock_i(clock_i),
         .rst_b_i(rst_b_i),
         .slot_pick_i(code_ram_slot_picks[g]),
         .cram_req_i(cram_req),
         .write_i(acc_write_i),
         .read_ok_i(single_pick),
         .wr_o(cram_wr_o[g]),
         .rd_o(cram_rd_o[g])
      );
   end

   // first stage registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_q <= '0;
         wdata_q <= '0;
         common_wr_q <= 1'b0;
         common_rd_q <= 1'b0;
         src1_q <= page_select_pkg::SRC_NONE;
         slot1_q <= page_select_pkg::IDX_SLOT1;
         selrd1_q <= page_select_pkg::SEL_RESET;
      end else begin
         addr_q <= acc_addr_i;
         wdata_q <= acc_wdata_i;
         common_wr_q <= common_req && acc_write_i;
         common_rd_q <= common_req && is_read;
         src1_q <= src1_d;
         slot1_q <= slot_idx;
         selrd1_q <= sel_q;
      end
   end

   // second stage: wait for the targets to answer
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         src2_q <= page_select_pkg::SRC_NONE;
         slot2_q <= page_select_pkg::IDX_SLOT1;
         selrd2_q <= page_select_pkg::SEL_RESET;
         ign_pipe_q <= '0;
         ref_pipe_q <= '0;
      end else begin
         src2_q <= src1_q;
         slot2_q <= slot1_q;
         selrd2_q <= selrd1_q;
         ign_pipe_q <= {ign_pipe_q[0], nothing_req};
         ref_pipe_q <= {ref_pipe_q[0], refused_req};
      end
   end

   // answer mux; refused and ignored reads return zero
   always_comb begin
      case (src2_q)
         page_select_pkg::SRC_SEL: rdata_d = selrd2_q;
         page_select_pkg::SRC_CRAM: rdata_d = cram_rdata_i[slot2_q];
         page_select_pkg::SRC_COMMON: rdata_d = common_rdata_i;
         default: rdata_d = page_select_pkg::RDATA_NONE;
      endcase
   end

   // third stage: all answers share one latency, so the engine needs no per-target timing
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= page_select_pkg::RDATA_NONE;
         rvalid_q <= 1'b0;
         ignored_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= src2_q != page_select_pkg::SRC_NONE;
         ignored_q <= ign_pipe_q[1];
         refused_q <= ref_pipe_q[1];
      end
   end

   assign acc_rdata_o = rdata_q;
   assign acc_rvalid_o = rvalid_q;
   assign acc_ignored_o = ignored_q;
   assign acc_refused_o = refused_q;

   // shared address and data; only the strobes say which target acts
   assign cram_addr_o = addr_q;
   assign cram_wdata_o = wdata_q;
   assign common_wr_o = common_wr_q;
   assign common_rd_o = common_rd_q;
   assign common_addr_o = addr_q;
   assign common_wdata_o = wdata_q;

   assign page_sel_o = sel_q;
   assign common_page_o = common_page;
   assign code_ram_slot_picks_o = code_ram_slot_picks;

endmodule : spi_memory_page_select

/* File: page_far_model.sv */
// behavioural code RAMs and common page answering read strobes
`timescale 1ns/1ps
module page_far_model (
   input wire logic clock_i,
   input wire logic [2:0] rd_i,
   input wire logic crd_i,
   input wire logic [9:0] addr_i,
   input wire logic [9:0] caddr_i,
   output logic [2:0][15:0] rdata_o,
   output logic [15:0] crdata_o
);
   // data valid the cycle after a strobe, inverted otherwise so stale data never matches
   always @(posedge clock_i) begin
      for (int k = 0; k < 3; k++) begin
         rdata_o[k] <= rd_i[k] ? {2'(k), 4'hA, addr_i} : ~{2'(k), 4'hA, addr_i};
      end
      crdata_o <= crd_i ? {6'h35, caddr_i} : ~{6'h35, caddr_i};
   end
endmodule : page_far_model

/* File: page_select_sva.sv */
// checker for the page selector's routing at the decoder ports
`timescale 1ns/1ps
module page_select_sva (
   input logic clock_i,
   input logic rst_b_i,
   input logic acc_valid_i,
   input logic acc_write_i,
   input logic [9:0] acc_addr_i,
   input logic [15:0] acc_wdata_i,
   input logic acc_rvalid_o,
   input logic acc_ignored_o,
   input logic acc_refused_o,
   input logic [2:0] cram_wr_o,
   input logic [2:0] cram_rd_o,
   input logic [9:0] cram_addr_o,
   input logic common_wr_o,
   input logic common_rd_o,
   input logic [15:0] page_sel_o,
   input logic common_page_o,
   input logic [2:0] code_ram_slot_picks_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // request classes; the top address never counts as memory traffic
   wire top = acc_valid_i && acc_addr_i == 10'h3FF;
   wire wsel = top && acc_write_i;
   wire other = acc_valid_i && acc_addr_i != 10'h3FF;
   wire rd = other && !acc_write_i;
   wire many = (code_ram_slot_picks_o & (code_ram_slot_picks_o - 3'h1)) != 3'h0;
   wire busy = (cram_wr_o | cram_rd_o) != 3'h0 || common_wr_o || common_rd_o;
   sequence no_strobe;
      !busy;
   endsequence
   a_reset_empty:
      assert property ($rose(rst_b_i) |-> page_sel_o == 16'h0000) else $error("selector not clear");
   a_common_store:
      assert property (wsel && acc_wdata_i[8] |=> page_sel_o == 16'h0100) else $error("bad common");
   a_pick_store:
      assert property (wsel && !acc_wdata_i[8] |=> page_sel_o == {13'h0000, $past(acc_wdata_i[2:0])})
      else $error("bad pick store");
   a_top_private:
      assert property (top |=> no_strobe) else $error("top address reached memory");
   a_idle_ignore:
      assert property (other && page_sel_o == 16'h0000 |=> no_strobe ##2 acc_ignored_o)
      else $error("idle access not ignored");
   a_single_read:
      assert property (rd && !page_sel_o[8] && code_ram_slot_picks_o != 3'h0 && !many
         |=> cram_rd_o == $past(code_ram_slot_picks_o) ##2 acc_rvalid_o) else $error("bad read");
   a_cram_write:
      assert property (other && acc_write_i && !page_sel_o[8]
         |=> cram_wr_o == $past(code_ram_slot_picks_o) && !common_wr_o) else $error("bad write");
   a_bcast_refuse:
      assert property (rd && many |=> no_strobe ##2 acc_refused_o && !acc_rvalid_o)
      else $error("broadcast read not refused");
   a_common_route:
      assert property (other && page_sel_o[8] |=> (cram_wr_o | cram_rd_o) == 3'h0
         && common_wr_o == $past(acc_write_i) && common_rd_o == !$past(acc_write_i))
      else $error("bad common routing");
   a_pick_view:
      assert property (code_ram_slot_picks_o == page_sel_o[2:0]) else $error("pick view wrong");
   a_common_view:
      assert property (common_page_o == page_sel_o[8]) else $error("common view wrong");
   a_top_hidden:
      assert property ((cram_wr_o | cram_rd_o) != 3'h0 |-> cram_addr_o != 10'h3FF)
      else $error("top address on code RAM strobe");
endmodule : page_select_sva

bind spi_memory_page_select page_select_sva chk (.clock_i, .rst_b_i, .acc_valid_i, .acc_write_i,
   .acc_addr_i, .acc_wdata_i, .acc_rvalid_o, .acc_ignored_o, .acc_refused_o, .cram_wr_o,
   .cram_rd_o, .cram_addr_o, .common_wr_o, .common_rd_o, .page_sel_o, .common_page_o,
   .code_ram_slot_picks_o);

/* File: tb_spi_memory_page_select.sv */
// self-checking bench for the serial page selector
`timescale 1ns/1ps
module tb_spi_memory_page_select;
   typedef struct packed {
      logic [15:0] sel;
      logic w;
      logic [9:0] a;
      logic [7:0] s;
      logic [2:0] f;
   } row_t;
   // selector written, access, strobes {wr, rd, cwr, crd}, flags {rvalid, ignored, refused}
   row_t rows [19] = '{
      '{16'h0000, 1'b0, 10'h010, 8'h00, 3'h2}, '{16'hFE00, 1'b1, 10'h3FE, 8'h00, 3'h2},
      '{16'h0001, 1'b1, 10'h123, 8'h20, 3'h0}, '{16'h0002, 1'b1, 10'h124, 8'h40, 3'h0},
      '{16'h0004, 1'b1, 10'h000, 8'h80, 3'h0}, '{16'h0001, 1'b0, 10'h001, 8'h04, 3'h4},
      '{16'h0002, 1'b0, 10'h045, 8'h08, 3'h4}, '{16'h00F4, 1'b0, 10'h3FE, 8'h10, 3'h4},
      '{16'h0003, 1'b1, 10'h200, 8'h60, 3'h0}, '{16'h0005, 1'b1, 10'h201, 8'hA0, 3'h0},
      '{16'h0006, 1'b1, 10'h202, 8'hC0, 3'h0}, '{16'h0007, 1'b1, 10'h3FE, 8'hE0, 3'h0},
      '{16'h0003, 1'b0, 10'h200, 8'h00, 3'h1}, '{16'h0005, 1'b0, 10'h201, 8'h00, 3'h1},
      '{16'h0006, 1'b0, 10'h202, 8'h00, 3'h1}, '{16'h0007, 1'b0, 10'h203, 8'h00, 3'h1},
      '{16'h0107, 1'b1, 10'h1FF, 8'h02, 3'h0}, '{16'h01FF, 1'b0, 10'h1E3, 8'h01, 3'h4},
      '{16'h0004, 1'b0, 10'h3FF, 8'h00, 3'h4}};
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic acc_valid_i = 1'b0;
   logic acc_write_i = 1'b0;
   logic [9:0] acc_addr_i = 10'h000;
   logic [15:0] acc_wdata_i = 16'h0000;
   logic [9:0] cram_addr_o, common_addr_o;
   logic [15:0] acc_rdata_o, cram_wdata_o, common_wdata_o, common_rdata_i, page_sel_o, p, d;
   logic acc_rvalid_o, acc_ignored_o, acc_refused_o, common_wr_o, common_rd_o, common_page_o;
   logic [2:0] cram_wr_o, cram_rd_o, code_ram_slot_picks_o;
   logic [2:0][15:0] cram_rdata_i;
   logic [7:0] s;
   logic [18:0] r;
   logic [25:0] aw;
   logic [25:0] cw;
   int bad_count = 0;
   int num_checks = 0;
   spi_memory_page_select dut (.clock_i, .rst_b_i, .acc_valid_i, .acc_write_i, .acc_addr_i,
      .acc_wdata_i, .acc_rdata_o, .acc_rvalid_o, .acc_ignored_o, .acc_refused_o, .cram_wr_o,
      .cram_rd_o, .cram_addr_o, .cram_wdata_o, .cram_rdata_i, .common_wr_o, .common_rd_o,
      .common_addr_o, .common_wdata_o, .common_rdata_i, .page_sel_o, .common_page_o,
      .code_ram_slot_picks_o);
   page_far_model far (.clock_i, .rd_i(cram_rd_o), .crd_i(common_rd_o), .addr_i(cram_addr_o),
      .caddr_i(common_addr_o), .rdata_o(cram_rdata_i), .crdata_o(common_rdata_i));
   initial forever #20 clock_i = ~clock_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one access; strobes seen the cycle after, the answer two cycles later
   task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] dd);
      @(negedge clock_i);
      acc_valid_i = 1'b1;
      acc_write_i = w;
      acc_addr_i = a;
      acc_wdata_i = dd;
      @(negedge clock_i);
      acc_valid_i = 1'b0;
      s = {cram_wr_o, cram_rd_o, common_wr_o, common_rd_o};
      aw = {cram_addr_o, cram_wdata_o};
      cw = {common_addr_o, common_wdata_o};
      repeat (2) @(negedge clock_i);
      r = {acc_rvalid_o, acc_ignored_o, acc_refused_o, acc_rdata_o};
   endtask : acc
   // read answer: selector, common page or one channel; zero when no data comes back
   function automatic logic [15:0] want(input row_t x, input logic [15:0] v);
      if (!x.f[2]) return 16'h0000;
      if (x.a == 10'h3FF) return v;
      if (x.s[0]) return {6'h35, x.a};
      return {x.s[4], x.s[3], 4'hA, x.a};
   endfunction : want
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (2000) @(posedge clock_i);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (20) @(negedge clock_i);
      rst_b_i = 1'b1;
      @(negedge clock_i);
      chk({16'h0000, page_sel_o}, 32'h0000_0000);
      for (int i = 0; i < 19; i++) begin
         d = {8'h5A, 8'(i)};
         acc(1'b1, 10'h3FF, rows[i].sel);
         chk({5'h00, s, r}, {5'h00, 8'h00, 3'h0, 16'h0000});
         p = rows[i].sel[8] ? 16'h0100 : {13'h0000, rows[i].sel[2:0]};
         chk({12'h000, common_page_o, code_ram_slot_picks_o, page_sel_o},
            {12'h000, p[8], p[2:0], p});
         acc(rows[i].w, rows[i].a, d);
         chk({5'h00, s, r}, {5'h00, rows[i].s, rows[i].f, want(rows[i], p)});
         if (rows[i].s[7:5] != 3'h0) chk({6'h00, aw}, {6'h00, rows[i].a, d});
         if (rows[i].s[1:0] != 2'h0) chk({6'h00, cw}, {6'h00, rows[i].a, d});
      end
      $display("table rows done");
      // selector write and read back to back: the new page applies at once
      @(negedge clock_i);
      acc_valid_i = 1'b1;
      acc_write_i = 1'b1;
      acc_addr_i = 10'h3FF;
      acc_wdata_i = 16'h0002;
      @(negedge clock_i);
      acc_write_i = 1'b0;
      acc_addr_i = 10'h055;
      @(negedge clock_i);
      acc_valid_i = 1'b0;
      chk({29'h0, cram_rd_o}, {29'h0, 3'h2});
      repeat (2) @(negedge clock_i);
      chk({15'h0, acc_rvalid_o, acc_rdata_o}, {15'h0, 1'b1, 6'h1A, 10'h055});
      $display("back to back done");
      // reset in mid-run drops the selection
      rst_b_i = 1'b0;
      repeat (2) @(negedge clock_i);
      rst_b_i = 1'b1;
      chk({16'h0000, page_sel_o}, 32'h0000_0000);
      acc(1'b0, 10'h055, 16'h0000);
      chk({5'h00, s, r}, {5'h00, 8'h00, 3'h2, 16'h0000});
      $display("mid-run reset done");
      close_out();
   end
endmodule : tb_spi_memory_page_select
